/* common/usb_node_regs.svh */
// What this block does
// - seven endpoint pipes, control FIFO eight bytes
// - node always in exactly one state
// - line events latched, masked onto interrupt
// - activity while suspended and idle wakes unit
// - three ms idle sets suspend detect flag
// - remote wake only when host enabled it
// - resuming drives K between one and five ms
// - resume or reset in suspend raises event
// - node answers tokens within ten ms
// - address then endpoint decoded, others ignored
// - endpoint zero bidirectional, odd tx, even rx
// - duplicate numbers go to lower endpoint unless it is iso without room
// - opposite directions with same number independent
// - default address bit, no isochronous on zero
// - endpoint zero packet resent after error, flushable
// - errored receptions discarded, good ones reported
`ifndef USB_NODE_REGS_SVH
`define USB_NODE_REGS_SVH
// -------------------------------------------------------------
// register offsets
// -------------------------------------------------------------
`define OFS_FADDR 8'h00
`define OFS_NST 8'h04
`define OFS_EVT 8'h08
`define OFS_ALTMSK 8'h0c
`define OFS_CTRL 8'h10
`define OFS_EP0_DATA 8'h14
`define OFS_EP0_STAT 8'h18
`define OFS_SEL 8'h1c
`define OFS_EPC_FIRST 8'h20
`define OFS_EPC_LAST 8'h38
// -------------------------------------------------------------
// field positions
// -------------------------------------------------------------
`define FADDR_EN 7
`define EPC_EN 4
`define EPC_ISO 5
`define EPC_DFLT 6
`define EV_SUSPEND 0
`define EV_RESUME 1
`define EV_RESET 2
`define ST_TX_ARM 4
`define ST_RX_ARM 5
`define ST_RX_DONE 6
`define ST_TX_DONE 7
`define ST_FLUSH 8
`define NST_RESET 2'h0
`define NST_RESUME 2'h1
`define NST_OPER 2'h2
`define NST_SUSPEND 2'h3
// -------------------------------------------------------------
// timing
// -------------------------------------------------------------
`define CLK_MHZ 40
`define SUSPEND_IDLE_US 3000
`define RESUME_K_US 1000
`define RESET_SE0_NS 2500
`define RESET_SE0_CYCLES ((`RESET_SE0_NS * `CLK_MHZ + 999) / 1000)
`define EP0_DEPTH 8
`define EP_DEPTH 64
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

/* common/usb_node_pkg.sv */
package usb_node_pkg;
  // node operating states, one-hot
  typedef enum logic [3:0] {
    st_oper = 4'h1,
    st_susp = 4'h2,
    st_resu = 4'h4,
    st_rst = 4'h8
  } node_state_e;
  // token kinds from the serial_interface_engine
  typedef enum logic [1:0] {
    pid_out = 2'h0,
    pid_in = 2'h1,
    pid_setup = 2'h2,
    pid_sof = 2'h3
  } pid_e;
  // one decoded token
  typedef struct packed {
    pid_e pid;
    logic [6:0] addr;
    logic [3:0] ep;
  } token_s;
endpackage : usb_node_pkg

/* design/usb_node_state_endpoint_logic.sv */
// Our own choices: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ps
`include "usb_node_regs.svh"
module usb_node_state_endpoint_logic #(
  parameter int unsigned SUSPEND_CYCLES = `SUSPEND_IDLE_US * `CLK_MHZ,
  parameter int unsigned RESUME_K_CYCLES = `RESUME_K_US * `CLK_MHZ,
  parameter int unsigned NUM_EP = 7
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite slave
  input wire logic awvalid,
  output logic awready,
  input wire logic [7:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [7:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // usb line pins
  input wire logic dp_in,
  input wire logic dm_in,
  output logic dp_out,
  output logic dm_out,
  output logic dp_oe_n,
  output logic dm_oe_n,
  // serial_interface_engine side
  input wire logic tok_valid,
  input usb_node_pkg::token_s tok,
  input wire logic rx_valid,
  input wire logic [7:0] rx_byte,
  input wire logic pkt_end,
  input wire logic pkt_err,
  input wire logic tx_req,
  output logic [7:0] tx_byte,
  // endpoint fifo selection and levels
  output logic [NUM_EP-1:0] ep_sel,
  output logic ep_sel_valid,
  input wire logic [NUM_EP-1:0] fifo_full,
  input wire logic [NUM_EP-1:0] fifo_empty,
  // interrupt_controller_unit and wakeup_unit
  output logic irq,
  output logic wakeup
);
  localparam int unsigned SW = $clog2(SUSPEND_CYCLES + 1);
  localparam int unsigned KW = $clog2(RESUME_K_CYCLES + 1);
  localparam int unsigned RW = $clog2(`RESET_SE0_CYCLES + 1);

  // refuse counts the logic cannot serve
  if (SUSPEND_CYCLES < 2 || RESUME_K_CYCLES < 1 || NUM_EP != 7) begin : g_chk
    $error("unsupported parameter values");
  end

  // -------------------------------------------------------------
  // line synchroniser
  // -------------------------------------------------------------
  logic [2:0] dp_sync_q, dm_sync_q;
  logic dp_q, dm_q;
  // a change counts only when stages two and three agree
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dp_sync_q <= 3'h0;
      dm_sync_q <= 3'h0;
      dp_q <= 1'b0;
      dm_q <= 1'b0;
    end else begin
      dp_sync_q <= {dp_sync_q[1:0], dp_in};
      dm_sync_q <= {dm_sync_q[1:0], dm_in};
      if (dp_sync_q[1] == dp_sync_q[2]) dp_q <= dp_sync_q[2];
      if (dm_sync_q[1] == dm_sync_q[2]) dm_q <= dm_sync_q[2];
    end
  end
  logic line_j, line_k, line_se0, line_j_q, line_k_q;
  assign line_j = dp_q & ~dm_q;
  assign line_k = ~dp_q & dm_q;
  assign line_se0 = ~dp_q & ~dm_q;

  // -------------------------------------------------------------
  // line condition detection
  // -------------------------------------------------------------
  usb_node_pkg::node_state_e state_q;
  logic [SW-1:0] idle_cnt_q;
  logic [RW-1:0] se0_cnt_q;
  logic susp_hit, reset_hit, resume_hit, driving_k;
  assign susp_hit = line_j && idle_cnt_q == SW'(SUSPEND_CYCLES - 1);
  assign reset_hit = line_se0 && se0_cnt_q == RW'(`RESET_SE0_CYCLES - 1);
  assign resume_hit = (state_q == usb_node_pkg::st_susp) &&
                      line_k && !line_k_q;
  // idle and se0 counters saturate so each event fires once
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      idle_cnt_q <= '0;
      se0_cnt_q <= '0;
      line_j_q <= 1'b0;
      line_k_q <= 1'b0;
    end else begin
      line_j_q <= line_j;
      line_k_q <= line_k;
      if (!line_j || driving_k) idle_cnt_q <= '0;
      else if (idle_cnt_q != SW'(SUSPEND_CYCLES)) begin
        idle_cnt_q <= idle_cnt_q + SW'(1);
      end
      if (!line_se0) se0_cnt_q <= '0;
      else if (se0_cnt_q != RW'(`RESET_SE0_CYCLES)) begin
        se0_cnt_q <= se0_cnt_q + RW'(1);
      end
    end
  end

  // -------------------------------------------------------------
  // axi4-lite slave
  // -------------------------------------------------------------
  logic aw_got_q, w_got_q, bvalid_q, rvalid_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q, rdata_q, rd_data;
  logic [3:0] wstrb_q;
  logic [1:0] bresp_q, rresp_q;
  logic wr_fire, rd_fire, wr_ok, rd_ok, wr_b0;
  assign awready = !aw_got_q && !bvalid_q;
  assign wready = !w_got_q && !bvalid_q;
  assign arready = !rvalid_q;
  assign wr_fire = aw_got_q && w_got_q && !bvalid_q;
  assign rd_fire = arvalid && arready;
  assign wr_b0 = wr_fire && wstrb_q[0];
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign rvalid = rvalid_q;
  assign rdata = rdata_q;
  assign rresp = rresp_q;

  // mapped word offsets
  function automatic logic mapped(input logic [7:0] a);
    mapped = (a[1:0] == 2'h0) && (a <= `OFS_EPC_LAST);
  endfunction : mapped
  assign wr_ok = mapped(awaddr_q);
  assign rd_ok = mapped(araddr);

  // address and data accepted in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      bvalid_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0;
      wstrb_q <= 4'h0;
      bresp_q <= `RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        aw_got_q <= 1'b1;
        awaddr_q <= awaddr;
      end
      if (wvalid && wready) begin
        w_got_q <= 1'b1;
        wdata_q <= wdata;
        wstrb_q <= wstrb;
      end
      if (wr_fire) begin
        bvalid_q <= 1'b1;
        bresp_q <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
        aw_got_q <= 1'b0;
        w_got_q <= 1'b0;
      end else if (bvalid_q && bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // read answer one cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0;
      rresp_q <= `RESP_OKAY;
    end else if (rd_fire) begin
      rvalid_q <= 1'b1;
      rdata_q <= rd_ok ? rd_data : 32'h0;
      rresp_q <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
    end else if (rvalid_q && rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // -------------------------------------------------------------
  // control registers
  // -------------------------------------------------------------
  logic [7:0] faddr_q;
  logic [1:0] nst_q;
  logic [2:0] evt_q, altmsk_q, ev_set;
  logic rwe_q;
  logic [6:0] epc_q [NUM_EP];
  logic [NUM_EP-1:0] sel_last_q;
  assign ev_set = {reset_hit, resume_hit, susp_hit};
  // set beats a clear that lands in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      faddr_q <= 8'h00;
      altmsk_q <= 3'h0;
      rwe_q <= 1'b0;
      evt_q <= 3'h0;
    end else begin
      if (wr_b0 && awaddr_q == `OFS_FADDR) faddr_q <= wdata_q[7:0];
      if (wr_b0 && awaddr_q == `OFS_ALTMSK) altmsk_q <= wdata_q[2:0];
      if (wr_b0 && awaddr_q == `OFS_CTRL) rwe_q <= wdata_q[0];
      if (wr_b0 && awaddr_q == `OFS_EVT) begin
        evt_q <= (evt_q & ~wdata_q[2:0]) | ev_set;
      end else begin
        evt_q <= evt_q | ev_set;
      end
    end
  end

  // endpoint control registers, one per pipe
  for (genvar i = 0; i < NUM_EP; i++) begin : g_epc
    always_ff @(posedge aclk) begin
      if (!aresetn) epc_q[i] <= 7'h00;
      else if (wr_b0 && awaddr_q == `OFS_EPC_FIRST + 8'(4 * i)) begin
        epc_q[i] <= wdata_q[6:0];
      end
    end
  end

  // interrupt line towards the interrupt_controller_unit
  always_ff @(posedge aclk) begin
    if (!aresetn) irq <= 1'b0;
    else irq <= |(evt_q & altmsk_q);
  end

  // -------------------------------------------------------------
  // node state machine
  // -------------------------------------------------------------
  logic [KW-1:0] k_cnt_q;
  logic nst_wr;
  assign nst_wr = wr_b0 && awaddr_q == `OFS_NST;
  assign driving_k = (state_q == usb_node_pkg::st_resu) &&
                     k_cnt_q != '0;
  // a bus reset overrides any software request
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= usb_node_pkg::st_rst;
      nst_q <= `NST_RESET;
      k_cnt_q <= '0;
    end else begin
      if (k_cnt_q != '0) k_cnt_q <= k_cnt_q - KW'(1);
      if (reset_hit) begin
        state_q <= usb_node_pkg::st_rst;
        nst_q <= `NST_RESET;
      end else if (nst_wr) begin
        case (wdata_q[1:0])
          `NST_OPER: begin
            state_q <= usb_node_pkg::st_oper;
            nst_q <= `NST_OPER;
          end
          `NST_SUSPEND: begin
            state_q <= usb_node_pkg::st_susp;
            nst_q <= `NST_SUSPEND;
          end
          `NST_RESUME: begin
            if (rwe_q) begin
              state_q <= usb_node_pkg::st_resu;
              nst_q <= `NST_RESUME;
              k_cnt_q <= KW'(RESUME_K_CYCLES);
            end
          end
          default: begin
            state_q <= usb_node_pkg::st_rst;
            nst_q <= `NST_RESET;
          end
        endcase
      end
    end
  end

  // k is driven only while the resume count runs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dp_oe_n <= 1'b1;
      dm_oe_n <= 1'b1;
      dp_out <= 1'b0;
      dm_out <= 1'b0;
      wakeup <= 1'b0;
    end else begin
      dp_oe_n <= !driving_k;
      dm_oe_n <= !driving_k;
      dp_out <= 1'b0;
      dm_out <= driving_k;
      wakeup <= (state_q == usb_node_pkg::st_susp) &&
                line_j_q && !line_j;
    end
  end

  // -------------------------------------------------------------
  // address and endpoint decode
  // -------------------------------------------------------------
  logic addr_hit, dflt_hit, is_in, tok_use;
  logic [NUM_EP-1:0] cand, sel;
  logic ep0_tx_arm_q, ep0_rx_arm_q;
  assign addr_hit = faddr_q[`FADDR_EN] && tok.addr == faddr_q[6:0];
  assign dflt_hit = epc_q[0][`EPC_DFLT] && tok.addr == 7'h00;
  assign is_in = tok.pid == usb_node_pkg::pid_in;
  assign tok_use = tok_valid && tok.pid != usb_node_pkg::pid_sof;
  // all pipes compared at once; pipe zero both ways, odd pipes send, even ones from two up receive
  for (genvar i = 0; i < NUM_EP; i++) begin : g_dec
    logic dir_ok, room_ok;
    if (i == 0) begin : g_ctl
      assign dir_ok = is_in ? ep0_tx_arm_q : ep0_rx_arm_q;
      assign room_ok = 1'b1;
      assign cand[i] = dir_ok && room_ok && (addr_hit || dflt_hit) &&
                       epc_q[i][3:0] == tok.ep;
    end else begin : g_data
      assign dir_ok = (i % 2 == 1) == is_in;
      // isochronous pipes pass on when an out pipe is full or an in pipe is empty
      assign room_ok = !epc_q[i][`EPC_ISO] ||
                       (is_in ? !fifo_empty[i] : !fifo_full[i]);
      assign cand[i] = dir_ok && room_ok && addr_hit &&
                       epc_q[i][`EPC_EN] &&
                       epc_q[i][3:0] == tok.ep;
    end
  end
  assign sel = cand & (~cand + NUM_EP'(1));

  // selection pulse to the fifo datapath
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ep_sel <= '0;
      ep_sel_valid <= 1'b0;
      sel_last_q <= '0;
    end else begin
      ep_sel_valid <= tok_use && sel != '0;
      if (tok_use) begin
        ep_sel <= sel;
        sel_last_q <= sel;
      end
    end
  end

  // -------------------------------------------------------------
  // control endpoint fifo
  // -------------------------------------------------------------
  logic [7:0] ep0_mem_q [`EP0_DEPTH];
  logic [3:0] ep0_cnt_q;
  logic [2:0] ep0_rd_q;
  logic ep0_act_q, ep0_in_q, rx_done_q, tx_done_q;
  logic stat_wr, data_wr, data_rd, ep0_full;
  assign stat_wr = wr_b0 && awaddr_q == `OFS_EP0_STAT;
  assign data_wr = wr_b0 && awaddr_q == `OFS_EP0_DATA;
  assign data_rd = rd_fire && araddr == `OFS_EP0_DATA && rx_done_q;
  assign ep0_full = ep0_cnt_q == 4'(`EP0_DEPTH);
  // one packet of up to eight bytes in either direction
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ep0_cnt_q <= 4'h0;
      ep0_rd_q <= 3'h0;
      ep0_act_q <= 1'b0;
      ep0_in_q <= 1'b0;
      ep0_tx_arm_q <= 1'b0;
      ep0_rx_arm_q <= 1'b0;
      rx_done_q <= 1'b0;
      tx_done_q <= 1'b0;
      tx_byte <= 8'h00;
    end else begin
      if (stat_wr) begin
        ep0_tx_arm_q <= wdata_q[`ST_TX_ARM];
        ep0_rx_arm_q <= wdata_q[`ST_RX_ARM];
        if (wdata_q[`ST_RX_DONE]) rx_done_q <= 1'b0;
        if (wdata_q[`ST_TX_DONE]) tx_done_q <= 1'b0;
        if (wstrb_q[1] && wdata_q[`ST_FLUSH]) begin
          ep0_cnt_q <= 4'h0;
          ep0_rd_q <= 3'h0;
          rx_done_q <= 1'b0;
        end
      end
      if (data_wr && ep0_tx_arm_q && !ep0_act_q && !ep0_full) begin
        ep0_mem_q[ep0_cnt_q[2:0]] <= wdata_q[7:0];
        ep0_cnt_q <= ep0_cnt_q + 4'h1;
      end
      if (data_rd) ep0_rd_q <= ep0_rd_q + 3'h1;
      if (tok_use && sel[0]) begin
        ep0_act_q <= 1'b1;
        ep0_in_q <= is_in;
        ep0_rd_q <= 3'h0;
        if (!is_in) ep0_cnt_q <= 4'h0;
      end
      if (ep0_act_q && ep0_in_q && tx_req) begin
        tx_byte <= ep0_mem_q[ep0_rd_q];
        ep0_rd_q <= ep0_rd_q + 3'h1;
      end
      if (ep0_act_q && !ep0_in_q && rx_valid && !ep0_full) begin
        ep0_mem_q[ep0_cnt_q[2:0]] <= rx_byte;
        ep0_cnt_q <= ep0_cnt_q + 4'h1;
      end
      if (ep0_act_q && pkt_end) begin
        ep0_act_q <= 1'b0;
        ep0_rd_q <= 3'h0;
        if (ep0_in_q && !pkt_err) begin
          ep0_cnt_q <= 4'h0;
          ep0_tx_arm_q <= 1'b0;
          tx_done_q <= 1'b1;
        end else if (!ep0_in_q && pkt_err) begin
          ep0_cnt_q <= 4'h0;
        end else if (!ep0_in_q) begin
          rx_done_q <= 1'b1;
          ep0_rx_arm_q <= 1'b0;
        end
      end
    end
  end

  // -------------------------------------------------------------
  // read mux
  // -------------------------------------------------------------
  always_comb begin
    rd_data = 32'h0;
    case (araddr)
      `OFS_FADDR: rd_data[7:0] = faddr_q;
      `OFS_NST: rd_data[1:0] = nst_q;
      `OFS_EVT: rd_data[2:0] = evt_q;
      `OFS_ALTMSK: rd_data[2:0] = altmsk_q;
      `OFS_CTRL: rd_data[0] = rwe_q;
      `OFS_EP0_DATA: rd_data[7:0] = ep0_mem_q[ep0_rd_q];
      `OFS_EP0_STAT: begin
        rd_data[3:0] = ep0_cnt_q;
        rd_data[`ST_TX_ARM] = ep0_tx_arm_q;
        rd_data[`ST_RX_ARM] = ep0_rx_arm_q;
        rd_data[`ST_RX_DONE] = rx_done_q;
        rd_data[`ST_TX_DONE] = tx_done_q;
      end
      `OFS_SEL: rd_data[NUM_EP-1:0] = sel_last_q;
      default: begin
        if (araddr >= `OFS_EPC_FIRST) begin
          rd_data[6:0] = epc_q[3'(araddr[4:2] ^ 3'h0) -
                               3'(`OFS_EPC_FIRST >> 2)];
        end
      end
    endcase
  end
endmodule : usb_node_state_endpoint_logic

/* dv/usb_node_sva.sv */
`timescale 1ns/1ps
module usb_node_sva #(
  parameter int unsigned RESUME_K_CYCLES = 40000,
  parameter int unsigned NUM_EP = 7
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // register bus answers
  input wire logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic [31:0] rdata,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [1:0] bresp,
  // line drive
  input wire logic dp_out,
  input wire logic dm_out,
  input wire logic dp_oe_n,
  input wire logic dm_oe_n,
  input wire logic wakeup,
  // token decode
  input wire logic tok_valid,
  input usb_node_pkg::token_s tok,
  input wire logic [NUM_EP-1:0] ep_sel,
  input wire logic ep_sel_valid
);
  // ----
  // helpers
  // ----
  logic [31:0] k_q;
  // cycles of k drive so far, restarts when released
  always_ff @(posedge aclk) begin
    if (!aresetn || dm_oe_n) begin
      k_q <= '0;
    end else begin
      k_q <= k_q + 32'h1;
    end
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ----
  // properties
  // ----
  a_sel_onehot: assert property (ep_sel_valid |-> $onehot(ep_sel))
    else $error("pipe selection not one-hot");
  a_sel_cause: assert property (ep_sel_valid |-> $past(tok_valid) &&
    $past(tok.pid) != usb_node_pkg::pid_sof)
    else $error("pipe selected without a token");
  a_oe_paired: assert property (dp_oe_n == dm_oe_n)
    else $error("line enables differ");
  a_k_level: assert property (!dm_oe_n |-> !dp_out && dm_out)
    else $error("driven level is not k");
  a_k_length: assert property ($rose(dm_oe_n) |-> k_q == RESUME_K_CYCLES)
    else $error("k drive length wrong");
  a_wake_pulse: assert property (wakeup |=> !wakeup)
    else $error("wakeup longer than one cycle");
  a_b_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped early");
  a_r_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped early");
  a_ar_block: assert property (arvalid && arready |=> rvalid && !arready)
    else $error("read not answered or taken twice");
endmodule : usb_node_sva

bind usb_node_state_endpoint_logic usb_node_sva #(
  .RESUME_K_CYCLES(RESUME_K_CYCLES), .NUM_EP(NUM_EP)) u_sva (
  .aclk, .aresetn, .arready, .rvalid, .rready, .rdata, .bvalid, .bready,
  .bresp, .dp_out, .dm_out, .dp_oe_n, .dm_oe_n, .wakeup, .tok_valid, .tok,
  .ep_sel, .ep_sel_valid, .arvalid);

/* dv/usb_host_model.sv */
`timescale 1ns/1ps
module usb_host_model (
  // clock
  input wire logic aclk,
  // line, resolved with the node's drive
  output logic dp_in,
  output logic dm_in,
  input wire logic dp_out,
  input wire logic dm_out,
  input wire logic dp_oe_n,
  input wire logic dm_oe_n,
  // engine side traffic
  output logic tok_valid,
  output usb_node_pkg::token_s tok,
  output logic rx_valid,
  output logic [7:0] rx_byte,
  output logic pkt_end,
  output logic pkt_err,
  output logic tx_req,
  input wire logic [7:0] tx_byte
);
  logic hp, hm;
  // node drive wins while its enables are low
  assign dp_in = dp_oe_n ? hp : dp_out;
  assign dm_in = dm_oe_n ? hm : dm_out;
  // idle bus is j, so no reset event at start
  initial begin
    {hp, hm} = 2'b10;
    {tok_valid, rx_valid, pkt_end, pkt_err, tx_req} = '0;
    tok = '0;
    rx_byte = '0;
  end
  task line(input logic p, input logic m);
    @(posedge aclk);
    hp <= p;
    hm <= m;
  endtask : line
  // fields turned round after use so stale values never match
  task token(input usb_node_pkg::pid_e p, input logic [6:0] a,
             input logic [3:0] e);
    @(posedge aclk);
    tok_valid <= 1'b1;
    tok <= {p, a, e};
    @(posedge aclk);
    tok_valid <= 1'b0;
    tok <= usb_node_pkg::token_s'(~{p, a, e});
  endtask : token
  task put(input logic [7:0] v);
    @(posedge aclk);
    rx_valid <= 1'b1;
    rx_byte <= v;
    @(posedge aclk);
    rx_valid <= 1'b0;
    rx_byte <= ~v;
  endtask : put
  task get(output logic [7:0] v);
    @(posedge aclk);
    tx_req <= 1'b1;
    @(posedge aclk);
    tx_req <= 1'b0;
    @(negedge aclk);
    v = tx_byte;
  endtask : get
  task end_pkt(input logic err);
    @(posedge aclk);
    pkt_end <= 1'b1;
    pkt_err <= err;
    @(posedge aclk);
    pkt_end <= 1'b0;
    pkt_err <= ~err;
  endtask : end_pkt
  // host carries the k on, then ends it with a short se0
  task finish_resume();
    line(1'b0, 1'b1);
    repeat (40) @(posedge aclk);
    line(1'b0, 1'b0);
    @(posedge aclk);
    line(1'b1, 1'b0);
  endtask : finish_resume
endmodule : usb_host_model

/* dv/tb_usb_node_state_endpoint_logic.sv */
`timescale 1ns/1ps
`include "usb_node_regs.svh"
module tb_usb_node_state_endpoint_logic;
  localparam int unsigned SUSP = 200;
  localparam int unsigned KCYC = 20;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, dp_in, dm_in, dp_out, dm_out;
  logic dp_oe_n, dm_oe_n, tok_valid, rx_valid, pkt_end, pkt_err, tx_req;
  logic ep_sel_valid, irq, wakeup;
  logic [7:0] awaddr, araddr, rx_byte, tx_byte, b;
  logic [31:0] wdata, rdata, d;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, r;
  logic [6:0] ep_sel, fifo_full, fifo_empty;
  usb_node_pkg::token_s tok;
  int n_fail, checks;
  usb_node_state_endpoint_logic #(.SUSPEND_CYCLES(SUSP),
    .RESUME_K_CYCLES(KCYC)) DUT (.aclk, .aresetn, .awvalid, .awready,
    .awaddr, .wvalid, .wready, .wdata, .wstrb, .bvalid, .bready, .bresp,
    .arvalid, .arready, .araddr, .rvalid, .rready, .rdata, .rresp, .dp_in,
    .dm_in, .dp_out, .dm_out, .dp_oe_n, .dm_oe_n, .tok_valid, .tok,
    .rx_valid, .rx_byte, .pkt_end, .pkt_err, .tx_req, .tx_byte, .ep_sel,
    .ep_sel_valid, .fifo_full, .fifo_empty, .irq, .wakeup);
  usb_host_model h (.aclk, .dp_in, .dm_in, .dp_out, .dm_out, .dp_oe_n,
    .dm_oe_n, .tok_valid, .tok, .rx_valid, .rx_byte, .pkt_end, .pkt_err,
    .tx_req, .tx_byte);
  // ----
  // clock, closing and watchdog
  // ----
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end
  task tally_and_finish();
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : tally_and_finish
  // the whole sequence needs well under a thousand cycles
  initial begin
    repeat (20000) @(posedge aclk);
    n_fail++;
    tally_and_finish();
  end
  // ----
  // bus tasks
  // ----
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // ready sampled mid-cycle, acted on at the next rising edge
  task wr(input logic [7:0] a, input logic [31:0] v);
    logic ta, tw;
    @(posedge aclk);
    {awvalid, wvalid, bready} <= 3'b111;
    awaddr <= a;
    wdata <= v;
    {ta, tw} = 2'b00;
    while (!(ta && tw)) begin
      @(negedge aclk);
      ta = ta | (awvalid & awready);
      tw = tw | (wvalid & wready);
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end
    do @(negedge aclk); while (bvalid !== 1'b1);
    @(posedge aclk);
    bready <= 1'b0;
  endtask : wr
  task rd(input logic [7:0] a);
    logic t;
    @(posedge aclk);
    {arvalid, rready} <= 2'b11;
    araddr <= a;
    t = 1'b0;
    while (!t) begin
      @(negedge aclk);
      t = arready;
      @(posedge aclk);
    end
    arvalid <= 1'b0;
    do @(negedge aclk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    @(posedge aclk);
    rready <= 1'b0;
  endtask : rd
  task tsel(input usb_node_pkg::pid_e p, input logic [6:0] a,
            input logic [3:0] e, input logic v, input logic [6:0] s);
    h.token(p, a, e);
    @(negedge aclk);
    chk(ep_sel_valid, v);
    if (v) chk(ep_sel, s);
  endtask : tsel
  // ----
  // tests
  // ----
  initial begin
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata} = '0;
    wstrb = 4'hf;
    {fifo_full, fifo_empty} = '0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`OFS_NST);
    chk(d, 32'h0);
    rd(8'h40);
    chk(r, `RESP_SLVERR);
    chk(d, 32'h0);
    wr(`OFS_ALTMSK, 32'h7);
    $display("test registers done");
    repeat (SUSP + 20) @(posedge aclk);
    rd(`OFS_EVT);
    chk(d[`EV_SUSPEND], 1'b1);
    chk(irq, 1'b1);
    wr(`OFS_NST, `NST_SUSPEND);
    h.line(1'b0, 1'b1);
    for (int i = 0; i < 10 && wakeup !== 1'b1; i++) @(negedge aclk);
    chk(wakeup, 1'b1);
    rd(`OFS_EVT);
    chk(d[`EV_RESUME], 1'b1);
    wr(`OFS_EVT, 32'h7);
    rd(`OFS_EVT);
    chk(d, 32'h0);
    chk(irq, 1'b0);
    $display("test suspend done");
    h.line(1'b1, 1'b0);
    repeat (KCYC) @(posedge aclk);
    wr(`OFS_NST, `NST_RESUME);
    repeat (4) @(negedge aclk);
    chk(dm_oe_n, 1'b1);
    wr(`OFS_CTRL, 32'h1);
    // second pass asks for resume again after the first k drive has ended
    for (int j = 0; j < 2; j++) begin
      wr(`OFS_NST, `NST_RESUME);
      for (int i = 0; i < 6 && dm_oe_n; i++) @(negedge aclk);
      chk({dp_oe_n, dm_oe_n, dp_out, dm_out}, 4'b0001);
      for (int i = 0; i < KCYC + 4 && !dm_oe_n; i++) @(negedge aclk);
      chk(dm_oe_n, 1'b1);
    end
    wr(`OFS_NST, `NST_OPER);
    h.finish_resume();
    h.line(1'b0, 1'b0);
    repeat (110) @(posedge aclk);
    h.line(1'b1, 1'b0);
    rd(`OFS_EVT);
    chk(d[`EV_RESET], 1'b1);
    $display("test resume and reset done");
    wr(`OFS_FADDR, 32'h85);
    wr(8'h24, 32'h13);
    wr(8'h2c, 32'h13);
    wr(8'h28, 32'h13);
    tsel(usb_node_pkg::pid_in, 7'h5, 4'h3, 1'b1, 7'h02);
    tsel(usb_node_pkg::pid_out, 7'h5, 4'h3, 1'b1, 7'h04);
    tsel(usb_node_pkg::pid_in, 7'h6, 4'h3, 1'b0, 7'h00);
    tsel(usb_node_pkg::pid_sof, 7'h5, 4'h3, 1'b0, 7'h00);
    wr(8'h24, 32'h03);
    tsel(usb_node_pkg::pid_in, 7'h5, 4'h3, 1'b1, 7'h08);
    wr(8'h28, 32'h35);
    wr(8'h30, 32'h35);
    tsel(usb_node_pkg::pid_out, 7'h5, 4'h5, 1'b1, 7'h04);
    @(posedge aclk);
    fifo_full <= 7'h04;
    tsel(usb_node_pkg::pid_out, 7'h5, 4'h5, 1'b1, 7'h10);
    $display("test decode done");
    wr(8'h20, 32'h40);
    wr(`OFS_EP0_STAT, 32'h10);
    wr(`OFS_EP0_DATA, 32'ha1);
    wr(`OFS_EP0_DATA, 32'hb2);
    for (int k = 0; k < 2; k++) begin
      tsel(usb_node_pkg::pid_in, 7'h0, 4'h0, 1'b1, 7'h01);
      h.get(b);
      chk(b, 8'ha1);
      h.get(b);
      chk(b, 8'hb2);
      h.end_pkt(k == 0);
    end
    rd(`OFS_EP0_STAT);
    chk({d[`ST_TX_DONE], d[`ST_TX_ARM], d[3:0]}, 6'h20);
    wr(`OFS_EP0_STAT, 32'ha0);
    for (int k = 0; k < 2; k++) begin
      tsel(usb_node_pkg::pid_out, 7'h0, 4'h0, 1'b1, 7'h01);
      h.put(8'h5c);
      h.end_pkt(k == 0);
      rd(`OFS_EP0_STAT);
      chk(d[`ST_RX_DONE], k == 1);
    end
    chk(d[3:0], 4'h1);
    rd(`OFS_EP0_DATA);
    chk(d, 32'h5c);
    wr(`OFS_EP0_STAT, 32'h100);
    rd(`OFS_EP0_STAT);
    chk(d, 32'h0);
    $display("test endpoint zero done");
    tally_and_finish();
  end
endmodule : tb_usb_node_state_endpoint_logic
